// file: common/clk_sel_pkg.sv
/*
  Constants and carrier types for the system clock source selection block.
  Assumes one 100 MHz bus clock and an APB master with 32-bit data.
*/
package clk_sel_pkg;
  localparam logic [11:0] ctrl_off    = 12'h000;
  localparam logic [11:0] stat_off    = 12'h004;
  localparam logic [11:0] irq_off     = 12'h008;
  localparam logic [11:0] mask_off    = 12'h00C;
  // control fields
  localparam int sel_lsb    = 0;
  localparam int spll_bit   = 2;
  localparam int ircf_lsb   = 4;
  localparam int ircf_w     = 4;
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;
  // event bits
  localparam int ev_switch  = 0;
  localparam int ev_fail    = 1;
  localparam int ev_ready   = 2;
  localparam int ev_w       = 3;
  localparam int ost_cycles = 1024;
  localparam int fail_ns    = 2000;
  localparam int clk_ns     = 10;
  localparam int fail_cycles = fail_ns / clk_ns;

  typedef enum logic [2:0] {
    low_power_crystal_mode      = 3'b000,
    medium_gain_crystal_mode    = 3'b001,
    high_gain_crystal_mode      = 3'b010,
    ext_rc_mode                 = 3'b011,
    internal_clock_mode         = 3'b100,
    ext_clock_low_power_mode    = 3'b101,
    ext_clock_medium_power_mode = 3'b110,
    ext_clock_high_power_mode   = 3'b111
  } osc_mode_t;

  typedef enum logic [1:0] {
    src_primary  = 2'b00,
    src_timer1   = 2'b01,
    src_internal = 2'b10
  } src_t;

  typedef struct packed {
    logic [1:0] gain;
    logic       pin2_is_osc;
    logic       ext_clock;
    logic       crystal;
    logic [1:0] ec_range;
  } mode_info_t;
endpackage

// file: rtl/startup_timer.sv
/*
  Counts edges of an oscillator tick and flags ready after a set count.
  Assumes tick is a one-cycle pulse synchronous to clk_sys.
*/
module startup_timer #(
  parameter int count_max = 1024
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic restart,
  input  wire logic bypass,
  input  wire logic tick,
  output logic      ready
);
  logic [$clog2(count_max+1)-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || restart) begin
      cnt_q <= '0;
      ready <= 1'b0;
    end else if (bypass) begin
      ready <= 1'b1;
    end else if (tick && !ready) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == ($bits(cnt_q))'(count_max - 1)) begin
        ready <= 1'b1;
      end
    end
  end
endmodule

// file: rtl/failsafe_monitor.sv
/*
  Watches ticks of the external source; flags failure after a silent window.
  Assumes tick pulses synchronous to clk_sys.
*/
module failsafe_monitor #(
  parameter int timeout = 200
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic tick,
  output logic      failed
);
  logic [$clog2(timeout+1)-1:0] idle_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable || tick) begin
      idle_q <= '0;
      failed <= 1'b0;
    end else if (idle_q == ($bits(idle_q))'(timeout)) begin
      failed <= 1'b1;
    end else begin
      idle_q <= idle_q + 1'b1;
    end
  end
endmodule

// file: rtl/clock_source_select.sv
/*
  Clock source selection with APB registers, startup timer, failsafe
  monitor and sticky interrupt. Assumes oscillator activity arrives as
  tick pulses synchronous to clk_sys and mode straps are stable at reset.
*/
// Design decisions made here: the address map and the APB register port.
module clock_source_select
  import clk_sel_pkg::*;
#(
  parameter int ost_count  = ost_cycles,
  parameter int fail_count = fail_cycles
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire clk_sel_pkg::osc_mode_t oscillator_mode_bits,
  input  wire logic                 config_pll_enable,
  input  wire logic                 fail_monitor_enable,
  input  wire logic                 ext_tick,
  input  wire logic                 timer1_tick,
  input  wire logic                 timer1_ready,
  input  wire logic                 wake_up,
  output clk_sel_pkg::src_t         active_source,
  output clk_sel_pkg::mode_info_t   mode_info,
  output logic [3:0]                internal_divider,
  output logic                      pll_on,
  output logic                      cpu_run,
  output logic                      irq
);
  typedef enum logic [2:0] {
    st_run  = 3'b001,
    st_wait = 3'b010,
    st_fail = 3'b100
  } sw_state_t;

  sw_state_t  state_q;
  logic [1:0] sel_q;
  logic       spll_q;
  logic [3:0] ircf_q;
  logic [ev_w-1:0] stat_q, mask_q, ev;
  src_t       target;
  logic       ost_ready, failed, ext_is_ec, crystal, target_ready;
  logic       wr, rd;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign ext_is_ec = oscillator_mode_bits[2] && (oscillator_mode_bits[1:0] != 2'b00);
  assign crystal = (oscillator_mode_bits[2:1] == 2'b00) ||
                   (oscillator_mode_bits == high_gain_crystal_mode);
  assign target = sel_q[1] ? src_internal : (sel_q[0] ? src_timer1 : src_primary);

  startup_timer #(.count_max(ost_count)) u_ost (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .restart (wake_up),
    .bypass  (!crystal),
    .tick    (ext_tick),
    .ready   (ost_ready)
  );

  failsafe_monitor #(.timeout(fail_count)) u_failsafe_clock_monitor (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    // keep watching while fallen back, so a dead source cannot be re-entered
    .enable  (fail_monitor_enable && oscillator_mode_bits != internal_clock_mode
              && (active_source == src_primary || state_q == st_fail)),
    .tick    (ext_tick),
    .failed  (failed)
  );

  always_comb begin
    case (target)
      src_timer1:  target_ready = timer1_ready;
      src_internal: target_ready = 1'b1;
      default:     target_ready = ost_ready && !failed;
    endcase
  end

  // software control and mask registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_q  <= ctrl_rst[sel_lsb +: 2];
      spll_q <= ctrl_rst[spll_bit];
      ircf_q <= ctrl_rst[ircf_lsb +: ircf_w];
      mask_q <= '0;
    end else if (wr && paddr == ctrl_off) begin
      sel_q  <= pwdata[sel_lsb +: 2];
      spll_q <= pwdata[spll_bit];
      ircf_q <= pwdata[ircf_lsb +: ircf_w];
    end else if (wr && paddr == mask_off) begin
      mask_q <= pwdata[ev_w-1:0];
    end
  end

  // switch state machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q       <= st_run;
      active_source <= src_primary;
    end else begin
      case (state_q)
        st_run: begin
          if (failed) begin
            state_q       <= st_fail;
            active_source <= src_internal;
          end else if (target != active_source) begin
            state_q <= st_wait;
          end
        end
        st_wait: begin
          if (target == active_source) begin
            state_q <= st_run;
          end else if (target_ready) begin
            active_source <= target;
            state_q       <= st_run;
          end
        end
        st_fail: begin
          if (!failed && target != src_primary) begin
            state_q <= st_wait;
          end else if (!failed && ost_ready) begin
            active_source <= src_primary;
            state_q       <= st_run;
          end
        end
        default: state_q <= st_run;
      endcase
    end
  end

  assign ev[ev_switch] = state_q == st_wait && target_ready && target != active_source;
  assign ev[ev_fail]   = state_q == st_run && failed;
  assign ev[ev_ready]  = ost_ready && !cpu_run;

  // sticky status, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr && paddr == irq_off) ? pwdata[ev_w-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_q & ~((wr && paddr == irq_off) ? pwdata[ev_w-1:0] : '0)) | ev)
               & mask_q);
    end
  end

  // derived outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_info        <= '0;
      internal_divider <= '0;
      pll_on           <= 1'b0;
      cpu_run          <= 1'b0;
    end else begin
      mode_info.gain        <= oscillator_mode_bits[1:0];
      mode_info.crystal     <= crystal;
      mode_info.ext_clock   <= ext_is_ec;
      mode_info.pin2_is_osc <= crystal;
      mode_info.ec_range    <= ext_is_ec ? oscillator_mode_bits[1:0] : 2'b00;
      internal_divider      <= ircf_q;
      pll_on                <= config_pll_enable || spll_q;
      // no stop on missing ticks, only held while starting
      cpu_run <= (active_source != src_primary) || ost_ready;
    end
  end

  // apb slave, zero wait states
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {ctrl_off, stat_off, irq_off, mask_off});
      prdata  <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ctrl_off: prdata <= 32'(ircf_q) << ircf_lsb | 32'(spll_q) << spll_bit | 32'(sel_q);
          stat_off: prdata <= {26'h0, state_q, active_source, ost_ready};
          irq_off:  prdata <= 32'(stat_q);
          mask_off: prdata <= 32'(mask_q);
          default:  prdata <= '0;
        endcase
      end
    end
  end

  switch_waits_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == st_wait && !target_ready && target != active_source
    |=> $stable(active_source))
    else $error("source changed before ready");
  fail_falls_back_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == st_run && failed |=> active_source == src_internal)
    else $error("no fallback on failure");
  pll_follows_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    config_pll_enable |=> pll_on)
    else $error("pll not on with config bit");
  ec_no_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ext_is_ec && !wake_up |=> ost_ready)
    else $error("external clock waited on timer");
  internal_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_q[1] && state_q == st_wait && !failed |=> active_source == src_internal)
    else $error("1x did not select internal");
  irq_masked_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (stat_q & mask_q) == '0 && ev == '0 |=> !irq)
    else $error("irq without masked event");
  gain_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    crystal && $stable(oscillator_mode_bits) |=> mode_info.gain == oscillator_mode_bits[1:0])
    else $error("gain mismatch");
  apb_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    psel && !penable |=> pready)
    else $error("apb not ready");
  switch_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ev[ev_switch]);
  fail_c:   cover property (@(posedge clk_sys) disable iff (!rst_n) ev[ev_fail]);
  irq_c:    cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
endmodule

// file: verif/osc_model.sv
/*
  External oscillator model: one tick every per cycles while run is high.
  Assumes clk_sys from the bench; a stopped source gives no ticks at all.
*/
module osc_model #(
  parameter int per = 4
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      tick
);
  int cnt = 0;
  initial tick = 1'b0;
  always @(posedge clk_sys) begin
    cnt  <= (cnt + 1) % per;
    tick <= run && (cnt == 0);
  end
endmodule

// file: verif/test_system_clock_source_select.sv
/*
  Self-checking bench for clock_source_select with an oscillator model.
  Assumes the package offsets and the hand-over APB timing.
*/
module test_system_clock_source_select
  import clk_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int oscillator_startup_timer = 8;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ext_tick, t1_tick, pll_on, cpu_run, irq;
  logic        cfg_pll = 0, fsm_en = 0, t1_rdy = 0, wake = 0, run = 0;
  osc_mode_t   mode = ext_clock_high_power_mode;
  src_t        src;
  mode_info_t  info;
  logic [3:0]  div;
  note_t       q[$];
  int          err_count = 0, n_tests = 0, cyc = 0, seed = 97;

  clock_source_select #(.ost_count(oscillator_startup_timer), .fail_count(10)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oscillator_mode_bits(mode),
    .config_pll_enable(cfg_pll), .fail_monitor_enable(fsm_en),
    .ext_tick(ext_tick), .timer1_tick(t1_tick), .timer1_ready(t1_rdy),
    .wake_up(wake), .active_source(src), .mode_info(info),
    .internal_divider(div), .pll_on(pll_on), .cpu_run(cpu_run), .irq(irq));
  osc_model #(.per(4)) ext_u (.clk_sys(clk_sys), .run(run), .tick(ext_tick));
  osc_model #(.per(7)) t1_u (.clk_sys(clk_sys), .run(1'b1), .tick(t1_tick));

  initial forever #5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // write, or read expecting d under mask m; e is the expected error
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hFFFFFFFF, input logic e = 0);
    int n;
    n = 0;
    q.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
    @(posedge clk_sys) psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys) penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rst(input osc_mode_t m);
    @(posedge clk_sys) rst_n <= 0;
    mode <= m;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
  endtask

  task automatic wait_src(input src_t s);
    int n;
    n = 0;
    while (src !== s && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk("source", s, src);
  endtask

  always @(posedge clk_sys) begin
    note_t t;
    if (psel && penable && pready === 1'b1) begin
      t = q.pop_front();
      chk("prdata", t.d, prdata & t.m);
      chk("pslverr", t.e, pslverr);
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    logic [1:0] g;
    logic [3:0] r;
    int         k;
    int         t;
    src_t       sx[4];
    g = 0;
    sx = '{src_timer1, src_internal, src_internal, src_primary};
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys) run <= 0;
      rst(osc_mode_t'(m));
      repeat (4) @(negedge clk_sys);
      chk("crystal", m < 3, info.crystal);
      chk("ext_clock", m > 4, info.ext_clock);
      chk("pin2_osc", m < 3, info.pin2_is_osc);
      chk("source", src_primary, src);
      chk("run_early", m >= 3, cpu_run);
      if (m < 3) begin
        chk("gain_up", 1, m == 0 || info.gain > g);
        g = info.gain;
        @(posedge clk_sys) run <= 1;
        k = 0;
        t = 0;
        while (cpu_run !== 1'b1 && t < 400) begin
          @(negedge clk_sys);
          t++;
          k += ext_tick;
        end
        chk("ost_len", 1, k >= oscillator_startup_timer && cpu_run === 1'b1);
      end
      @(posedge clk_sys) run <= 0;
      wake <= 1;
      @(posedge clk_sys) wake <= 0;
      repeat (30) @(negedge clk_sys);
      chk("run_wake", m >= 3, cpu_run);
    end
    @(posedge clk_sys) run <= 1;
    rst(ext_clock_high_power_mode);
    apb(0, ctrl_off, ctrl_rst);
    apb(1, ctrl_off, 32'h1);
    repeat (20) @(negedge clk_sys);
    chk("hold", src_primary, src);
    @(posedge clk_sys) t1_rdy <= 1;
    for (int i = 0; i < 4; i++) begin
      apb(1, ctrl_off, (i + 1) % 4);
      wait_src(sx[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) cfg_pll <= i[1];
      apb(1, ctrl_off, {29'h0, i[0], 2'h0});
      repeat (2) @(negedge clk_sys);
      chk("pll_on", i[0] | i[1], pll_on);
    end
    repeat (4) begin
      r = $random(seed);
      apb(1, ctrl_off, {24'h0, r, 4'h0});
      repeat (2) @(negedge clk_sys);
      chk("divider", r, div);
      apb(0, ctrl_off, {24'h0, r, 4'h0});
    end
    apb(0, 12'h010, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, 12'h010, 32'h5, 32'h0, 1);
    apb(0, ctrl_off, {24'h0, r, 4'h0});
    apb(1, stat_off, 32'h0);
    apb(0, stat_off, 32'h1, 32'h1);
    apb(1, irq_off, 32'h7);
    apb(1, mask_off, 32'h0);
    @(posedge clk_sys) fsm_en <= 1;
    @(posedge clk_sys) run <= 0;
    wait_src(src_internal);
    repeat (2) @(negedge clk_sys);
    chk("irq_masked", 0, irq);
    apb(0, irq_off, 32'h2, 32'h2);
    apb(1, mask_off, 32'h2);
    repeat (2) @(negedge clk_sys);
    chk("irq_on", 1, irq);
    @(posedge clk_sys) run <= 1;
    apb(1, irq_off, 32'h2);
    repeat (2) @(negedge clk_sys);
    chk("irq_off", 0, irq);
    apb(0, irq_off, 32'h0, 32'h2);
    conclude();
  end
endmodule
